/* File: verilog/boot_pkg.sv */
// Purpose: shared constants and types for the boot sequencer
// Assumes: sys_clk at 100 MHz
// Notes: identity-free; token and entry values are plain defaults
package boot_pkg;
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int RESET_WAIT_CLKS = 750_000;
  localparam int LINK_DELAY_NS = 200;
  localparam int LINK_DELAY_CLKS = LINK_DELAY_NS * (SYS_CLK_HZ / 1_000_000) / 1000;
  localparam int SPI_SCLK_HZ = 2_500_000;
  localparam int SPI_HALF_CLKS = SYS_CLK_HZ / (2 * SPI_SCLK_HZ);
  localparam logic [7:0] SPI_READ_CMD = 8'h03;
  localparam logic [23:0] SPI_ADDR = 24'h000000;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_BYPASS = 32'h0d15ab1e;
  localparam logic [31:0] NULL_CHAN = 32'h0000ff02;
  localparam logic [7:0] END_TOKEN = 8'h01;
  localparam int SEC_BOOT_BIT = 5;
  localparam logic [15:0] RAM_BASE = 16'h0000;
  localparam logic [10:0] OTP_BASE = 11'h000;
  localparam int FIFO_DEPTH = 8;
  localparam int TOKEN_W = 9;

  typedef enum {SRC_JTAG, SRC_RSVD, SRC_LINK, SRC_SPI, SRC_OTP} boot_src_e;
  typedef struct packed {logic [5:0] ref_div; logic [11:0] mult; logic [2:0] out_div;} pll_cfg_s;
  typedef struct packed {logic ctrl; logic [7:0] data;} token_s;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction

  function automatic pll_cfg_s pll_preset(input logic hi, input logic lo);
    unique case ({hi, lo})
      2'b00: return '{6'h00, 12'h07a, 3'h1};
      2'b11: return '{6'h00, 12'h077, 3'h2};
      2'b10: return '{6'h00, 12'h031, 3'h2};
      default: return '{6'h00, 12'h017, 3'h2};
    endcase
  endfunction
endpackage

/* File: verilog/boot_loader_sequencer.sv */
// Purpose: reset wait, strap decode and image load for one tile
// Assumes: straps static through reset; ram takes a write whenever ram_ready
// Notes: link wires carry 9-bit tokens lsb first, ctrl flag last
// Notes on behaviour
// - while the reset pin is low, stay in reset with all gpio high impedance
// - after release wait 750000 clocks, then enable pulls and start boot
// - mode straps pick jtag wait, reserved, link, spi, or independent variants
// - secure-boot security bit forces boot from otp, mode straps ignored for the source
// - image is word count, four bytes per word, then crc word
// - a crc word equal to the bypass value skips the check
// - count and crc words arrive least significant byte first
// - program stored from lowest ram address, execution starts there
// - crc over count and program, reflected poly, init all ones, inverted
// - spi boot drives four pins as master at the scaled 2.5 MHz clock
// - spi boot sends one read command and a zero 24-bit address
// - spi runs clock polarity zero, phase zero
// - spi bytes are assembled least significant bit first
// - link enabled 200 ns after boot start, outbound low, inbound watched
// - link boot takes channel end 0, first word names the ack channel
// - after image and end token, send end to ack channel unless it is the null channel, free, jump
// - secure boot reads otp from address 0
// - oscillator select pin low picks resonator, high the internal oscillator
// - frequency straps preset pll divider and multiplier, reference divider 0
`timescale 1ns/1ps
`default_nettype none

module token_fifo #(parameter int WIDTH = 9, parameter int DEPTH = 8) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] cnt_reg;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (en) begin
      if (do_wr) mem_reg[wr_reg] <= in_data;
      if (do_wr) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (do_rd) rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

module boot_loader_sequencer import boot_pkg::*; #(
  parameter int WAIT_CLKS = RESET_WAIT_CLKS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic rst_pin_n,
  input wire logic oscillator_source_select,
  input wire logic freq_strap_low,
  input wire logic freq_strap_high,
  input wire logic [2:0] boot_mode_strap,
  input wire logic [31:0] security_reg,
  output logic gpio_hiz,
  output logic gpio_pull_en,
  output logic osc_internal_sel,
  output pll_cfg_s pll_cfg,
  output boot_src_e boot_source,
  output logic boot_independent,
  output logic spi_oe,
  output logic spi_sclk,
  output logic spi_ss_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic link_clk,
  input wire logic link_data,
  output logic link_oe,
  output logic [1:0] link_out,
  output logic link_pull_dn_en,
  output logic link_overrun,
  output logic chanend0_busy,
  output logic ack_valid,
  output logic [31:0] ack_channel,
  output logic otp_rd,
  output logic [10:0] otp_addr,
  input wire logic [31:0] otp_data,
  input wire logic otp_valid,
  input wire logic ram_ready,
  output logic ram_we,
  output logic [15:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic boot_jump,
  output logic boot_done,
  output logic crc_error
);
  typedef enum {ST_RESET, ST_WAIT, ST_DECODE, ST_LDELAY, ST_LOAD, ST_DONE, ST_HALT} st_e;
  typedef enum {P_ACK, P_CNT, P_PROG, P_CRC, P_END, P_FIN} p_e;
  st_e st_reg;
  p_e p_reg;
  logic [1:0] pin_sy, osc_sy, flo_sy, fhi_sy;
  logic [2:0] mode_sy0, mode_sy1;
  logic miso_sy0, miso_sy1, lc0, lc1, lc2, ld0, ld1;
  logic [19:0] cnt_reg;
  logic [4:0] bit_reg;
  logic [5:0] div_reg;
  logic [31:0] sh_reg, acc_reg, words_reg, crc_reg;
  logic [7:0] rx_reg;
  logic [8:0] tok_reg;
  logic [3:0] lbit_reg;
  logic [1:0] bc_reg, ob_reg;
  logic [31:0] ow_reg;
  logic cmd_reg, spush_reg, lpush_reg, ohave_reg, opend_reg;
  token_s ltok_reg, fin, fout;
  logic fin_valid, fin_ready, fout_valid;

  // strap and pin inputs come from the board, so they are double-flopped
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      pin_sy <= {pin_sy[0], rst_pin_n};
      osc_sy <= {osc_sy[0], oscillator_source_select};
      flo_sy <= {flo_sy[0], freq_strap_low};
      fhi_sy <= {fhi_sy[0], freq_strap_high};
      mode_sy0 <= boot_mode_strap;
      mode_sy1 <= mode_sy0;
      miso_sy0 <= spi_miso;
      miso_sy1 <= miso_sy0;
      {lc2, lc1, lc0} <= {lc1, lc0, link_clk};
      {ld1, ld0} <= {ld0, link_data};
    end
  end

  wire pin_up = pin_sy[1];
  wire secure = security_reg[SEC_BOOT_BIT];
  // source is still the old one while decoding, so the parser start slot reads the straps
  wire dec_link = !secure && mode_sy1[1:0] == 2'b10;
  wire is_link = boot_source == SRC_LINK;
  wire loading = st_reg == ST_LOAD && p_reg != P_FIN;
  wire spi_act = loading && boot_source == SRC_SPI;
  wire link_act = loading && is_link;
  wire otp_act = loading && boot_source == SRC_OTP;
  wire wait_end = cnt_reg == 20'(WAIT_CLKS - 1);
  wire ldly_end = cnt_reg == 20'(LINK_DELAY_CLKS - 1);
  wire tick = div_reg == 6'(SPI_HALF_CLKS - 1);
  wire spi_stall = !cmd_reg && bit_reg == '0 && !spi_sclk && !fin_ready;
  wire l_rise = lc1 && !lc2;
  wire pop = fout_valid && st_reg == ST_LOAD && p_reg != P_FIN && (p_reg != P_PROG || ram_ready);
  wire [31:0] word_in = {fout.data, acc_reg[31:8]};
  wire last_b = bc_reg == 2'h3;
  wire crc_ok = word_in == CRC_BYPASS || word_in == ~crc_reg;
  wire data_pop = pop && !fout.ctrl;

  // reset pin wins over every state, so a late low re-enters reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= ST_RESET;
      cnt_reg <= '0;
      boot_source <= SRC_JTAG;
      boot_independent <= 1'b0;
      pll_cfg <= '0;
      osc_internal_sel <= 1'b0;
      boot_jump <= 1'b0;
      ack_valid <= 1'b0;
      crc_error <= 1'b0;
    end else if (clk_en) begin
      boot_jump <= 1'b0;
      ack_valid <= 1'b0;
      cnt_reg <= cnt_reg + 20'h1;
      if (!pin_up) begin
        st_reg <= ST_RESET;
        cnt_reg <= '0;
        crc_error <= 1'b0;
      end else begin
        unique case (st_reg)
          ST_RESET: begin
            st_reg <= ST_WAIT;
            cnt_reg <= '0;
          end
          ST_WAIT: if (wait_end) st_reg <= ST_DECODE;
          ST_DECODE: begin
            cnt_reg <= '0;
            pll_cfg <= pll_preset(fhi_sy[1], flo_sy[1]);
            osc_internal_sel <= osc_sy[1];
            boot_independent <= mode_sy1[2] && mode_sy1[1];
            if (secure) begin
              boot_source <= SRC_OTP;
              st_reg <= ST_LOAD;
            end else if (!mode_sy1[1]) begin
              boot_source <= mode_sy1[0] ? SRC_RSVD : SRC_JTAG;
              st_reg <= ST_HALT;
            end else begin
              boot_source <= mode_sy1[0] ? SRC_SPI : SRC_LINK;
              st_reg <= mode_sy1[0] ? ST_LOAD : ST_LDELAY;
            end
          end
          ST_LDELAY: if (ldly_end) st_reg <= ST_LOAD;
          ST_LOAD: begin
            if (pop && p_reg == P_CRC && last_b && !crc_ok) begin
              crc_error <= 1'b1;
              st_reg <= ST_HALT;
            end else if (p_reg == P_FIN) begin
              st_reg <= ST_DONE;
              boot_jump <= 1'b1;
              ack_valid <= is_link && ack_channel != NULL_CHAN;
            end
          end
          ST_DONE, ST_HALT: st_reg <= st_reg;
        endcase
      end
    end
  end

  assign gpio_hiz = st_reg == ST_RESET || st_reg == ST_WAIT;
  assign gpio_pull_en = !gpio_hiz;
  assign boot_done = st_reg == ST_DONE;
  assign link_oe = is_link && (st_reg == ST_LOAD || st_reg == ST_DONE);
  assign link_out = 2'b00;
  assign link_pull_dn_en = !link_oe;
  assign chanend0_busy = is_link && st_reg == ST_LOAD;
  // select is held until sclk is back low, so a cut frame never ends on a high clock
  assign spi_ss_n = !spi_act && !spi_sclk;
  assign spi_oe = !spi_ss_n;

  // spi master, mode 0: mosi moves on the falling edge, miso sampled on the rising
  always_ff @(posedge sys_clk) begin
    if (rst || !spi_act) begin
      spi_sclk <= 1'b0;
      div_reg <= '0;
      bit_reg <= '0;
      cmd_reg <= 1'b1;
      spi_mosi <= SPI_READ_CMD[7];
      sh_reg <= {SPI_READ_CMD[6:0], SPI_ADDR, 1'b0};
      spush_reg <= 1'b0;
    end else if (clk_en) begin
      spush_reg <= 1'b0;
      div_reg <= (tick || spi_stall) ? '0 : div_reg + 6'h1;
      if (tick && !spi_stall) begin
        spi_sclk <= !spi_sclk;
        if (!spi_sclk) begin
          rx_reg <= {miso_sy1, rx_reg[7:1]};
          bit_reg <= bit_reg + 5'h1;
          if (cmd_reg && bit_reg == 5'h1f) begin
            cmd_reg <= 1'b0;
            bit_reg <= '0;
          end else if (!cmd_reg && bit_reg == 5'h07) begin
            bit_reg <= '0;
            spush_reg <= 1'b1;
          end
        end else begin
          spi_mosi <= sh_reg[31];
          sh_reg <= {sh_reg[30:0], 1'b0};
        end
      end
    end
  end

  // the link clock is sampled, not used as a clock; a full fifo drops tokens
  always_ff @(posedge sys_clk) begin
    if (rst || !link_act) begin
      lbit_reg <= '0;
      lpush_reg <= 1'b0;
    end else if (clk_en) begin
      lpush_reg <= 1'b0;
      if (l_rise) begin
        tok_reg <= {ld1, tok_reg[8:1]};
        lbit_reg <= (lbit_reg == 4'h8) ? '0 : lbit_reg + 4'h1;
        if (lbit_reg == 4'h8) begin
          ltok_reg <= {ld1, tok_reg[8:1]};
          lpush_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link_overrun <= 1'b0;
    end else if (clk_en) begin
      // a lost token outranks the clear, so the flag never hides a drop
      if (lpush_reg && !fin_ready) link_overrun <= 1'b1;
      else if (st_reg == ST_RESET) link_overrun <= 1'b0;
    end
  end

  // otp words are split into bytes lowest lane first
  assign otp_rd = otp_act && !ohave_reg && !opend_reg;
  always_ff @(posedge sys_clk) begin
    if (rst || !otp_act) begin
      otp_addr <= OTP_BASE;
      ohave_reg <= 1'b0;
      opend_reg <= 1'b0;
      ob_reg <= '0;
    end else if (clk_en) begin
      if (otp_rd) opend_reg <= 1'b1;
      if (opend_reg && otp_valid) begin
        ow_reg <= otp_data;
        ohave_reg <= 1'b1;
        opend_reg <= 1'b0;
      end
      if (ohave_reg && fin_ready) begin
        ob_reg <= ob_reg + 2'h1;
        if (ob_reg == 2'h3) begin
          ohave_reg <= 1'b0;
          otp_addr <= otp_addr + 11'h1;
        end
      end
    end
  end

  assign fin_valid = spush_reg || lpush_reg || (ohave_reg && otp_act);
  always_comb begin
    fin = '{1'b0, rx_reg};
    if (lpush_reg) fin = ltok_reg;
    else if (ohave_reg) fin = '{1'b0, ow_reg[8*ob_reg +: 8]};
  end

  token_fifo #(.WIDTH(TOKEN_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst(rst || st_reg == ST_RESET),
    .en(clk_en),
    .in_valid(fin_valid),
    .in_ready(fin_ready),
    .in_data(fin),
    .out_valid(fout_valid),
    .out_ready(pop),
    .out_data(fout)
  );

  // image parser; control tokens outside the end slot are discarded
  always_ff @(posedge sys_clk) begin
    if (rst || st_reg == ST_DECODE) begin
      p_reg <= dec_link ? P_ACK : P_CNT;
      bc_reg <= '0;
      crc_reg <= CRC_INIT;
      ram_addr <= RAM_BASE;
      ram_we <= 1'b0;
      ack_channel <= NULL_CHAN;
    end else if (clk_en) begin
      ram_we <= 1'b0;
      if (ram_we) ram_addr <= ram_addr + 16'h1;
      if (data_pop && p_reg != P_END) begin
        acc_reg <= word_in;
        bc_reg <= bc_reg + 2'h1;
        if (p_reg == P_CNT || p_reg == P_PROG) crc_reg <= crc_byte(crc_reg, fout.data);
      end
      if (data_pop) begin
        unique case (p_reg)
          P_ACK: if (last_b) begin
            ack_channel <= word_in;
            p_reg <= P_CNT;
          end
          P_CNT: if (last_b) begin
            words_reg <= word_in;
            p_reg <= (word_in == '0) ? P_CRC : P_PROG;
          end
          P_PROG: begin
            ram_we <= 1'b1;
            ram_wdata <= fout.data;
            if (last_b) words_reg <= words_reg - 32'h1;
            if (last_b && words_reg == 32'h1) p_reg <= P_CRC;
          end
          P_CRC: if (last_b && crc_ok) p_reg <= is_link ? P_END : P_FIN;
          P_END, P_FIN: p_reg <= p_reg;
        endcase
      end
      if (pop && fout.ctrl && p_reg == P_END && fout.data == END_TOKEN) p_reg <= P_FIN;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_hiz_in_reset: assert property (clk_en && !pin_up |=> gpio_hiz)
    else $error("gpio not high impedance in reset");
  a_pull_after_wait: assert property ($rose(gpio_pull_en) |-> $past(wait_end))
    else $error("pulls enabled before the reset wait ended");
  a_secure_otp: assert property (st_reg == ST_LOAD && secure |-> boot_source == SRC_OTP)
    else $error("secure boot did not pick otp");
  a_spi_idle_low: assert property (spi_ss_n |-> !spi_sclk ##1 !spi_sclk)
    else $error("sclk not low while deselected");
  a_spi_half: assert property (clk_en && $rose(spi_sclk) |-> $past(div_reg) == 6'(SPI_HALF_CLKS - 1))
    else $error("sclk half period wrong");
  a_link_low: assert property (link_oe |-> link_out == 2'b00 && !link_pull_dn_en)
    else $error("link outbound wires not low");
  a_ram_order: assert property (clk_en && ram_we ##1 clk_en |-> ram_addr == $past(ram_addr) + 16'h1)
    else $error("ram address not consecutive");
  a_no_bad_jump: assert property (crc_error |-> !boot_jump && st_reg != ST_DONE)
    else $error("jump after crc mismatch");
  a_ack_null: assert property (ack_valid |-> ack_channel != NULL_CHAN && $past(p_reg) == P_FIN)
    else $error("ack sent to null channel");
endmodule

`default_nettype wire

/* File: tb/spi_flash_model.sv */
// Purpose: boot flash on the far side of the spi pins
// Assumes: mode 0, master shifts mosi on sclk fall and samples miso on sclk rise
// Notes: image bytes go out lsb first; miso turns over while deselected
`timescale 1ns/1ps
`default_nettype none
module spi_flash_model (
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso
);
  logic [7:0] mem [0:63];
  logic [31:0] cmd;
  int nbit;
  realtime t_rise;
  realtime per;
  initial begin
    miso = 1'b0;
    nbit = 0;
    cmd = '0;
    per = 1.0e9;
    t_rise = 0;
  end
  always @(negedge ss_n) nbit = 0;
  // shortest sclk period seen; byte gaps from a full fifo would only lengthen it
  always @(posedge sclk) if (!ss_n) begin
    if (nbit > 0 && $realtime - t_rise < per) per = $realtime - t_rise;
    t_rise = $realtime;
    if (nbit < 32) cmd = {cmd[30:0], mosi};
    nbit++;
  end
  // count, program and crc follow the address, each byte lsb first
  always @(negedge sclk) if (!ss_n && nbit >= 32) begin
    miso = mem[(nbit - 32) / 8][(nbit - 32) % 8];
  end
  // released line does not keep its last level
  always @(posedge ss_n) miso = ~miso;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the boot sequencer
// Assumes: short reset wait; ram accepts writes at random
// Notes: ram writes are checked against a queue filled when the image is built
`timescale 1ns/1ps
`default_nettype none
module tb;
  import boot_pkg::*;
  localparam int W = 50;
  logic sys_clk, rst, rst_pin_n, oscillator_source_select, freq_strap_low, freq_strap_high;
  logic spi_miso, link_clk, link_data, otp_valid, ram_ready;
  logic [2:0] boot_mode_strap;
  logic [31:0] security_reg, otp_data, ack_channel;
  logic gpio_hiz, gpio_pull_en, osc_internal_sel, boot_independent, spi_oe, spi_sclk;
  logic spi_ss_n, spi_mosi, link_oe, link_pull_dn_en, link_overrun, chanend0_busy;
  logic ack_valid, otp_rd, ram_we, boot_jump, boot_done, crc_error;
  pll_cfg_s pll_cfg;
  boot_src_e boot_source;
  logic [1:0] link_out, seen;
  logic [10:0] otp_addr;
  logic [15:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] img [$];
  logic [23:0] exp_q [$];
  int mismatches, n_tests, cyc, waited;

  boot_loader_sequencer #(.WAIT_CLKS(W)) u_dut (.sys_clk, .rst, .clk_en(1'b1), .rst_pin_n,
    .oscillator_source_select, .freq_strap_low, .freq_strap_high, .boot_mode_strap,
    .security_reg, .gpio_hiz, .gpio_pull_en, .osc_internal_sel, .pll_cfg, .boot_source,
    .boot_independent, .spi_oe, .spi_sclk, .spi_ss_n, .spi_mosi, .spi_miso, .link_clk,
    .link_data, .link_oe, .link_out, .link_pull_dn_en, .link_overrun, .chanend0_busy,
    .ack_valid, .ack_channel, .otp_rd, .otp_addr, .otp_data, .otp_valid, .ram_ready,
    .ram_we, .ram_addr, .ram_wdata, .boot_jump, .boot_done, .crc_error);
  spi_flash_model u_flash (.sclk(spi_sclk), .ss_n(spi_ss_n), .mosi(spi_mosi), .miso(spi_miso));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen_v, input logic [63:0] exp_v);
    n_tests++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen_v, exp_v);
    end
  endtask

  // ram writes, timeout, and the otp responder live on one clocked process
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      wrap_up();
    end
    seen <= seen | {ack_valid === 1'b1, boot_jump === 1'b1};
    if (ram_we === 1'b1) chk({ram_addr, ram_wdata}, exp_q.size() ? exp_q.pop_front() : 'x);
    ram_ready <= #1 ($urandom_range(3) != 0);
    otp_valid <= #1 1'b0;
    if (otp_rd === 1'b1) begin
      otp_data <= #1 {img[4*otp_addr+3], img[4*otp_addr+2], img[4*otp_addr+1], img[4*otp_addr]};
      otp_valid <= #1 1'b1;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return gpio_pull_en;
      1: return boot_jump | seen[0];
      2: return crc_error;
      3: return link_oe;
      default: return ack_valid | seen[1];
    endcase
  endfunction

  task automatic await(input int k, input int lim);
    waited = 0;
    while (sig(k) !== 1'b1 && waited < lim) begin
      tick(1);
      waited++;
    end
    chk(sig(k), 1);
  endtask

  function automatic logic [31:0] crc_b(input logic [31:0] c, input logic [7:0] b);
    c ^= {24'h000000, b};
    repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    return c;
  endfunction

  function automatic logic [20:0] pll_exp(input logic [1:0] f);
    case (f)
      2'b00: return {6'h00, 12'h07a, 3'h1};
      2'b01: return {6'h00, 12'h017, 3'h2};
      2'b10: return {6'h00, 12'h031, 3'h2};
      default: return {6'h00, 12'h077, 3'h2};
    endcase
  endfunction

  // kind 0 good crc, 1 bypass word, 2 corrupted crc
  task automatic mk(input int cnt, input int kind);
    logic [31:0] c, w;
    img = {};
    exp_q = {};
    w = 32'(cnt);
    for (int i = 0; i < 4; i++) img.push_back(w[8*i +: 8]);
    for (int i = 0; i < 4 * cnt; i++) begin
      img.push_back(8'($urandom));
      exp_q.push_back({16'(i), img[4+i]});
    end
    c = 32'hffffffff;
    foreach (img[i]) c = crc_b(c, img[i]);
    c = (kind == 1) ? 32'h0d15ab1e : ~c ^ 32'(kind == 2);
    for (int i = 0; i < 4; i++) img.push_back(c[8*i +: 8]);
    foreach (img[i]) u_flash.mem[i] = img[i];
  endtask

  // straps stay put from before reset until the next boot
  task automatic boot(input logic [2:0] m, input logic [1:0] f, input logic sec);
    tick(1);
    rst_pin_n = 1'b0;
    boot_mode_strap = m;
    {freq_strap_high, freq_strap_low} = f;
    oscillator_source_select = f[0];
    security_reg = {26'($urandom), sec, 5'($urandom)};
    tick(4);
    chk(gpio_hiz, 1);
    chk(spi_oe | link_oe, 0);
    rst_pin_n = 1'b1;
    seen = 2'b00;
    await(0, 200);
    chk(waited >= W && waited <= W + 8, 1);
    tick(3);
    chk(osc_internal_sel, f[0]);
    chk(pll_cfg, pll_exp(f));
    chk(boot_source, sec ? 3'h4 : {1'b0, m[1:0]});
    if (!sec) chk(boot_independent, m[2] & m[1]);
  endtask

  task automatic tok(input logic [8:0] t);
    for (int i = 0; i < 9; i++) begin
      link_data = t[i];
      tick(8);
      link_clk = 1'b1;
      tick(8);
      link_clk = 1'b0;
    end
  endtask

  task automatic link_load(input logic [31:0] ack);
    await(3, 100);
    chk({link_out, link_pull_dn_en}, 0);
    for (int i = 0; i < 4; i++) tok({1'b0, ack[8*i +: 8]});
    chk(chanend0_busy, 1);
    foreach (img[i]) tok({1'b0, img[i]});
    tok({1'b1, END_TOKEN});
  endtask

  initial begin
    rst = 1'b1;
    rst_pin_n = 1'b1;
    {oscillator_source_select, freq_strap_low, freq_strap_high, boot_mode_strap} = '0;
    security_reg = '0;
    link_clk = 1'b0;
    link_data = 1'b0;
    {otp_valid, otp_data, ram_ready, seen} = '0;
    void'($urandom(32'hb81b));
    tick(2);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) boot(3'(i), 2'(i), 1'b0);
    mk(2, 0);
    boot(3'b011, 2'b11, 1'b0);
    chk(spi_oe, 1);
    await(1, 20000);
    chk({crc_error, 8'(exp_q.size())}, 0);
    chk(u_flash.cmd, 32'h03000000);
    chk(64'(int'(u_flash.per)), SPI_HALF_CLKS * 20);
    mk(1, 2);
    boot(3'b111, 2'b01, 1'b0);
    await(2, 20000);
    tick(50);
    chk(seen[0], 0);
    mk(2, 1);
    boot(3'b000, 2'b00, 1'b1);
    await(1, 3000);
    chk(exp_q.size(), 0);
    mk(1, 0);
    boot(3'b010, 2'b10, 1'b0);
    link_load(32'h00000a05);
    await(4, 300);
    chk({seen[0], ack_channel}, {1'b1, 32'h00000a05});
    tick(2);
    chk({chanend0_busy, 8'(exp_q.size())}, 0);
    chk({boot_done, link_overrun}, 2'b10);
    mk(0, 0);
    boot(3'b110, 2'b01, 1'b0);
    link_load(32'h0000ff02);
    await(1, 300);
    tick(2);
    chk(seen[1], 0);
    wrap_up();
  end
endmodule
`default_nettype wire
